// ---- smmu_unit.sv ----
// signed arithmetic, multiply, divide and range-maximum unit with AXI4-Lite access
//
// Behaviour
// - 32-bit signed subtract sets overflow when the true result exceeds 7fffffff.
// - 32-bit signed subtract sets underflow when the true result is below 80000000.
// - 16x16 signed multiply, 32-bit product, low half result 0, high half result 1.
// - short multiply sets equal flag only when whole product is zero.
// - short multiply negative flag follows bit 15 of upper product word.
// - 32x32 signed multiply writes 64-bit product over four words, low first.
// - long multiply sets equal flag only when all four words are zero.
// - long multiply negative flag follows top bit of the top product word.
// - 16/16 signed divide, quotient to result 0, remainder to result 1.
// - short divide equal flag when quotient zero, negative from quotient bit 15.
// - 32/32 signed divide, quotient in words 0-1, remainder in words 2-3.
// - long divide raises error when the whole 32-bit divisor is zero.
// - long divide equal when quotient zero, negative from upper quotient bit 15.
// - any operation errors when the checked pointer is not BCD or out of memory.
// - max search idle when condition off, else largest range word to destination.
// - report bit set writes position: absolute in data area, offset elsewhere.
// - ties report the lowest-addressed word holding the maximum.
// - word count is the three low BCD digits of control, 1 to 999.
// - control bit 15 clear compares unsigned, set compares signed.
// - max search errors on non-BCD count or range crossing memory areas.
// - max search equal when maximum is zero, negative from destination bit 15.
`timescale 1ns/10ps
`include "smmu_defines.svh"

module smmu_unit
	import smmu_pkg::*;
#(
	parameter int MEM_DEPTH = 64,
	parameter int AREA_BITS = 4
)(
	// clock and reset
	input  wire logic                     aclk,
	input  wire logic                     aresetn,
	// write address and data
	input  wire logic [`SMMU_ADDR_W-1:0]  awaddr,
	input  wire logic                     awvalid,
	output logic                          awready,
	input  wire logic [31:0]              wdata,
	input  wire logic [3:0]               wstrb,
	input  wire logic                     wvalid,
	output logic                          wready,
	// write response
	output logic [1:0]                    bresp,
	output logic                          bvalid,
	input  wire logic                     bready,
	// read address and data
	input  wire logic [`SMMU_ADDR_W-1:0]  araddr,
	input  wire logic                     arvalid,
	output logic                          arready,
	output logic [31:0]                   rdata,
	output logic [1:0]                    rresp,
	output logic                          rvalid,
	input  wire logic                     rready
);
	import smmu_pkg::*;

	localparam int AW = $clog2(MEM_DEPTH);

	// memory window is addressed by awaddr[7:2]
	if (MEM_DEPTH > 64 || MEM_DEPTH < 2 || (1 << AREA_BITS) > MEM_DEPTH)
		$error("smmu_unit: MEM_DEPTH must be 2..64 and hold one area");

	// =============================================================
	// helpers
	function automatic logic bcd_ok(input logic [15:0] v);
		bcd_ok = (v[3:0] < 4'ha) && (v[7:4] < 4'ha) && (v[11:8] < 4'ha) && (v[15:12] < 4'ha);
	endfunction : bcd_ok

	function automatic logic [13:0] bcd_bin(input logic [15:0] v);
		bcd_bin = 14'(v[15:12] * 1000 + v[11:8] * 100 + v[7:4] * 10 + v[3:0]);
	endfunction : bcd_bin

	function automatic smmu_word_t bin_bcd(input logic [9:0] v);
		bin_bcd = {4'h0, 4'(v / 100), 4'((v / 10) % 10), 4'(v % 10)};
	endfunction : bin_bcd

	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
		input logic [3:0] s);
		for (int i = 0; i < 4; i++)
			o[i*8 +: 8] = s[i] ? n[i*8 +: 8] : o[i*8 +: 8];
		merge = o;
	endfunction : merge

	// =============================================================
	// state
	smmu_state_t               state;
	smmu_op_t                  op_q;
	logic [31:0]               ctrl;
	logic [31:0]               opa;
	logic [31:0]               opb;
	smmu_word_t                ptr;
	smmu_word_t                mctl;
	smmu_word_t                range_first_word;
	smmu_word_t                res [4];
	smmu_word_t                mem [MEM_DEPTH];
	logic                      error_flag;
	logic                      equal_zero_flag;
	logic                      negative_flag;
	logic                      overflow_flag;
	logic                      underflow_flag;
	logic                      carry_flag;
	logic                      done;
	logic                      fin;
	logic [15:0]               idx;
	logic [15:0]               bidx;
	logic [9:0]                cnt;
	smmu_word_t                best;
	logic                      aw_held;
	logic                      w_held;
	logic [`SMMU_ADDR_W-1:0]   awaddr_q;
	logic [31:0]               wdata_q;
	logic [3:0]                wstrb_q;

	// =============================================================
	// write channel
	logic wr_fire;
	logic wr_mem;
	logic wr_map;
	logic start;
	assign wr_fire = aw_held && w_held && !bvalid;
	assign wr_mem = awaddr_q >= `SMMU_MEM_BASE && awaddr_q < `SMMU_MEM_BASE + 12'(MEM_DEPTH * 4);
	assign wr_map = wr_mem || awaddr_q <= `SMMU_MCTL_OFF + 12'h4;
	assign start = wr_fire && awaddr_q == `SMMU_CTRL_OFF && wstrb_q[1]
		&& wdata_q[`SMMU_CTRL_START] && state == st_idle;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			awready <= 1'b1;
			wready <= 1'b1;
			bvalid <= 1'b0;
			bresp <= `SMMU_RESP_OKAY;
			awaddr_q <= '0;
			wdata_q <= '0;
			wstrb_q <= '0;
		end
		else
		begin
			// address and data are taken in either order, answer after both
			if (awvalid && awready)
			begin
				aw_held <= 1'b1;
				awready <= 1'b0;
				awaddr_q <= awaddr;
			end
			if (wvalid && wready)
			begin
				w_held <= 1'b1;
				wready <= 1'b0;
				wdata_q <= wdata;
				wstrb_q <= wstrb;
			end
			if (wr_fire)
			begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				bvalid <= 1'b1;
				bresp <= wr_map ? `SMMU_RESP_OKAY : `SMMU_RESP_SLVERR;
			end
			if (bvalid && bready)
			begin
				bvalid <= 1'b0;
				awready <= 1'b1;
				wready <= 1'b1;
			end
		end
	end

	// software registers; operands are not locked while busy, caller keeps them
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl <= '0;
			opa <= '0;
			opb <= '0;
			ptr <= '0;
			mctl <= '0;
			range_first_word <= '0;
		end
		else if (wr_fire)
		begin
			unique case (awaddr_q)
				`SMMU_CTRL_OFF:  ctrl <= merge(ctrl, wdata_q, wstrb_q) & ~(32'h1 << `SMMU_CTRL_START);
				`SMMU_OPA_OFF:   opa <= merge(opa, wdata_q, wstrb_q);
				`SMMU_OPB_OFF:   opb <= merge(opb, wdata_q, wstrb_q);
				`SMMU_PTR_OFF:   ptr <= 16'(merge({16'h0, ptr}, wdata_q, wstrb_q));
				`SMMU_MCTL_OFF:  mctl <= 16'(merge({16'h0, mctl}, wdata_q, wstrb_q));
				`SMMU_RANGE_OFF: range_first_word <= 16'(merge({16'h0, range_first_word},
					wdata_q, wstrb_q));
				default: ;
			endcase
		end
	end

	// word memory; a write during a scan is seen by the scan
	always_ff @(posedge aclk)
	begin
		if (wr_fire && wr_mem)
			mem[awaddr_q[AW+1:2]] <= 16'(merge({16'h0, mem[awaddr_q[AW+1:2]]}, wdata_q, wstrb_q));
	end

	// =============================================================
	// read channel
	logic [31:0] rd_mux;
	logic        rd_map;
	always_comb
	begin
		rd_map = 1'b1;
		rd_mux = '0;
		if (araddr >= `SMMU_MEM_BASE && araddr < `SMMU_MEM_BASE + 12'(MEM_DEPTH * 4))
			rd_mux = {16'h0, mem[araddr[AW+1:2]]};
		else
		begin
			unique case (araddr)
				`SMMU_CTRL_OFF:   rd_mux = ctrl;
				`SMMU_OPA_OFF:    rd_mux = opa;
				`SMMU_OPB_OFF:    rd_mux = opb;
				`SMMU_PTR_OFF:    rd_mux = {16'h0, ptr};
				`SMMU_MCTL_OFF:   rd_mux = {16'h0, mctl};
				`SMMU_RANGE_OFF:  rd_mux = {16'h0, range_first_word};
				`SMMU_STATUS_OFF: rd_mux = {24'h0, carry_flag, underflow_flag, overflow_flag,
					negative_flag, equal_zero_flag, error_flag, done, state != st_idle};
				`SMMU_RES0_OFF:   rd_mux = {16'h0, res[0]};
				`SMMU_RES1_OFF:   rd_mux = {16'h0, res[1]};
				`SMMU_RES2_OFF:   rd_mux = {16'h0, res[2]};
				`SMMU_RES3_OFF:   rd_mux = {16'h0, res[3]};
				default:          rd_map = 1'b0;
			endcase
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= '0;
			rresp <= `SMMU_RESP_OKAY;
		end
		else if (arvalid && arready)
		begin
			arready <= 1'b0;
			rvalid <= 1'b1;
			rdata <= rd_mux;
			rresp <= rd_map ? `SMMU_RESP_OKAY : `SMMU_RESP_SLVERR;
		end
		else if (rvalid && rready)
		begin
			rvalid <= 1'b0;
			arready <= 1'b1;
		end
	end

	// =============================================================
	// arithmetic, one cycle; divisors forced nonzero so no x reaches the flops
	logic signed [33:0] diff;
	logic signed [31:0] prod16;
	logic signed [63:0] prod32;
	logic signed [15:0] q16;
	logic signed [15:0] r16;
	logic signed [31:0] q32;
	logic signed [31:0] r32;
	logic [15:0]        dv16;
	logic [31:0]        dv32;
	assign dv16 = opb[15:0] == 16'h0 ? 16'h1 : opb[15:0];
	assign dv32 = opb == 32'h0 ? 32'h1 : opb;
	assign diff = $signed({{2{opa[31]}}, opa}) - $signed({{2{opb[31]}}, opb})
		- $signed({33'h0, ctrl[`SMMU_CTRL_CYIN]});
	assign prod16 = $signed(opa[15:0]) * $signed(opb[15:0]);
	assign prod32 = $signed(opa) * $signed(opb);
	assign q16 = $signed(opa[15:0]) / $signed(dv16);
	assign r16 = $signed(opa[15:0]) % $signed(dv16);
	assign q32 = $signed(opa) / $signed(dv32);
	assign r32 = $signed(opa) % $signed(dv32);

	// pointer, count and span checks
	logic        ptr_bad;
	logic [9:0]  n_bin;
	logic        cnt_bad;
	logic [16:0] last;
	logic        span_bad;
	logic        cmp_gt;
	smmu_word_t  cur;
	assign ptr_bad = ctrl[`SMMU_CTRL_PTRCHK] && (!bcd_ok(ptr)
		|| bcd_bin(ptr) >= 14'(MEM_DEPTH));
	assign n_bin = 10'(bcd_bin({4'h0, mctl[11:0]}));
	assign cnt_bad = !bcd_ok({4'h0, mctl[11:0]}) || n_bin == 10'h0;
	assign last = {1'b0, range_first_word} + {7'h0, n_bin} - 17'h1;
	assign span_bad = last >= 17'(MEM_DEPTH)
		|| (last >> AREA_BITS) != 17'(range_first_word >> AREA_BITS);
	assign cur = mem[idx[AW-1:0]];
	assign cmp_gt = mctl[`SMMU_MCTL_SIGNED] ? $signed(cur) > $signed(best) : cur > best;

	// =============================================================
	// sequencer
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state <= st_idle;
			op_q <= op_sub;
			done <= 1'b0;
			fin <= 1'b0;
			idx <= '0;
			bidx <= '0;
			cnt <= '0;
			best <= '0;
			for (int i = 0; i < 4; i++)
				res[i] <= '0;
			error_flag <= 1'b0;
			equal_zero_flag <= 1'b0;
			negative_flag <= 1'b0;
			overflow_flag <= 1'b0;
			underflow_flag <= 1'b0;
			carry_flag <= 1'b0;
		end
		else
		begin
			fin <= 1'b0;
			unique case (state)
				st_idle:
				begin
					if (start)
					begin
						op_q <= smmu_op_t'(wdata_q[2:0]);
						done <= 1'b0;
						state <= st_calc;
						// unknown codes end as an error
						if (wdata_q[3:0] >= `SMMU_OP_COUNT)
							op_q <= op_max;
					end
				end
				st_calc:
				begin
					state <= st_idle;
					fin <= 1'b1;
					done <= 1'b1;
					error_flag <= 1'b0;
					if (ptr_bad || ctrl[3:0] >= `SMMU_OP_COUNT)
						error_flag <= 1'b1;
					else
					begin
						unique case (op_q)
							op_sub:
							begin
								{res[1], res[0]} <= diff[31:0];
								overflow_flag <= diff > 34'sh0_7fff_ffff;
								underflow_flag <= diff < -34'sh0_8000_0000;
								carry_flag <= {1'b0, opa} < {1'b0, opb} + {32'h0, ctrl[`SMMU_CTRL_CYIN]};
								equal_zero_flag <= diff[31:0] == 32'h0;
								negative_flag <= diff[31];
							end
							op_mul16:
							begin
								{res[1], res[0]} <= prod16;
								equal_zero_flag <= prod16 == 32'sh0;
								negative_flag <= prod16[31];
							end
							op_mul32:
							begin
								{res[3], res[2], res[1], res[0]} <= prod32;
								equal_zero_flag <= prod32 == 64'sh0;
								negative_flag <= prod32[63];
							end
							op_div16:
							begin
								if (opb[15:0] == 16'h0)
									error_flag <= 1'b1;
								else
								begin
									res[0] <= q16;
									res[1] <= r16;
									equal_zero_flag <= q16 == 16'sh0;
									negative_flag <= q16[15];
								end
							end
							op_div32:
							begin
								if (opb == 32'h0)
									error_flag <= 1'b1;
								else
								begin
									{res[1], res[0]} <= q32;
									{res[3], res[2]} <= r32;
									equal_zero_flag <= q32 == 32'sh0;
									negative_flag <= q32[31];
								end
							end
							op_max:
							begin
								// condition off: nothing changes but done
								if (!ctrl[`SMMU_CTRL_EXEC])
									error_flag <= error_flag;
								else if (cnt_bad || span_bad)
									error_flag <= 1'b1;
								else
								begin
									fin <= 1'b0;
									done <= 1'b0;
									state <= st_scan;
									best <= mem[range_first_word[AW-1:0]];
									bidx <= range_first_word;
									idx <= range_first_word + 16'h1;
									cnt <= n_bin - 10'h1;
								end
							end
						endcase
					end
				end
				st_scan:
				begin
					if (cnt == 10'h0)
					begin
						state <= st_idle;
						fin <= 1'b1;
						done <= 1'b1;
						res[0] <= best;
						if (mctl[`SMMU_MCTL_REPORT])
							res[1] <= (range_first_word >> AREA_BITS) == 16'h0
								? bin_bcd(bidx[9:0])
								: bin_bcd(10'(bidx - range_first_word));
						equal_zero_flag <= best == 16'h0;
						negative_flag <= best[15];
					end
					else
					begin
						// strictly greater keeps the lowest address on ties
						if (cmp_gt)
						begin
							best <= cur;
							bidx <= idx;
						end
						idx <= idx + 16'h1;
						cnt <= cnt - 10'h1;
					end
				end
			endcase
		end
	end

	// =============================================================
	// checks
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	logic signed [63:0] chk_diff;
	// sign-extend both operands, a bare size cast would zero-extend the mixed expression
	assign chk_diff = $signed({{32{opa[31]}}, opa}) - $signed({{32{opb[31]}}, opb})
		- $signed({63'h0, ctrl[`SMMU_CTRL_CYIN]});

	property p_sub_of;
		fin && op_q == op_sub && !error_flag |-> overflow_flag == (chk_diff > `SMMU_S32_MAX);
	endproperty
	a_sub_of: assert property (p_sub_of) else $error("overflow flag wrong");

	property p_sub_uf;
		fin && op_q == op_sub && !error_flag |-> underflow_flag == (chk_diff < `SMMU_S32_MIN);
	endproperty
	a_sub_uf: assert property (p_sub_uf) else $error("underflow flag wrong");

	property p_mul16;
		fin && op_q == op_mul16 && !error_flag |-> {res[1], res[0]}
			== $signed({{16{opa[15]}}, opa[15:0]}) * $signed({{16{opb[15]}}, opb[15:0]})
			&& equal_zero_flag == ({res[1], res[0]} == 32'h0) && negative_flag == res[1][15];
	endproperty
	a_mul16: assert property (p_mul16) else $error("short multiply wrong");

	property p_mul32_flags;
		fin && op_q == op_mul32 && !error_flag |-> negative_flag == res[3][15]
			&& equal_zero_flag == ({res[3], res[2], res[1], res[0]} == 64'h0);
	endproperty
	a_mul32_flags: assert property (p_mul32_flags) else $error("long multiply flags");

	property p_div16_zero;
		start && wdata_q[2:0] == 3'h3 && opb[15:0] == 16'h0 && !ptr_bad
			|-> ##2 fin && error_flag && $stable(res[0]);
	endproperty
	a_div16_zero: assert property (p_div16_zero) else $error("zero divisor missed");

	property p_div32_zero;
		start && wdata_q[2:0] == 3'h4 && opb == 32'h0 |-> ##2 fin && error_flag;
	endproperty
	a_div32_zero: assert property (p_div32_zero) else $error("long zero divisor missed");

	property p_ptr;
		// judged in the calc cycle, when the new control word is in place
		state == st_calc && ptr_bad |=> fin && error_flag;
	endproperty
	a_ptr: assert property (p_ptr) else $error("bad pointer missed");

	property p_max_flags;
		fin && op_q == op_max && $past(state) == st_scan
			|-> equal_zero_flag == (res[0] == 16'h0) && negative_flag == res[0][15];
	endproperty
	a_max_flags: assert property (p_max_flags) else $error("max flags wrong");

	property p_scan_len;
		state == st_calc && op_q == op_max && ctrl[3:0] < `SMMU_OP_COUNT
			&& ctrl[`SMMU_CTRL_EXEC] && !cnt_bad && !span_bad && !ptr_bad && n_bin == 10'h4
			|-> ##1 (state == st_scan) [*4] ##1 state == st_idle;
	endproperty
	a_scan_len: assert property (p_scan_len) else $error("scan length wrong");

	c_mul32: cover property (fin && op_q == op_mul32 && negative_flag);
	c_div_err: cover property (fin && op_q == op_div32 && error_flag);
	c_max_report: cover property (fin && op_q == op_max && mctl[`SMMU_MCTL_REPORT]);
	c_overflow: cover property (fin && overflow_flag);

endmodule : smmu_unit

// ---- smmu_defines.svh ----
// register offsets, field positions, response codes and limits of the arithmetic unit
`ifndef SMMU_DEFINES_SVH
`define SMMU_DEFINES_SVH

// =============================================================
// bus geometry
`define SMMU_ADDR_W      12
`define SMMU_RESP_OKAY   2'h0
`define SMMU_RESP_SLVERR 2'h2

// =============================================================
// register byte offsets
`define SMMU_CTRL_OFF    12'h000
`define SMMU_OPA_OFF     12'h004
`define SMMU_OPB_OFF     12'h008
`define SMMU_PTR_OFF     12'h00c
`define SMMU_MCTL_OFF    12'h010
`define SMMU_RANGE_OFF   12'h014
`define SMMU_STATUS_OFF  12'h018
`define SMMU_RES0_OFF    12'h020
`define SMMU_RES1_OFF    12'h024
`define SMMU_RES2_OFF    12'h028
`define SMMU_RES3_OFF    12'h02c
`define SMMU_MEM_BASE    12'h100

// =============================================================
// control register fields
`define SMMU_CTRL_OP_LSB 0
`define SMMU_CTRL_START  8
`define SMMU_CTRL_EXEC   9
`define SMMU_CTRL_CYIN   10
`define SMMU_CTRL_PTRCHK 11
`define SMMU_OP_COUNT    4'h6

// =============================================================
// status register fields
`define SMMU_ST_BUSY     0
`define SMMU_ST_DONE     1
`define SMMU_ST_ER       2
`define SMMU_ST_EQ       3
`define SMMU_ST_NEG      4
`define SMMU_ST_OF       5
`define SMMU_ST_UF       6
`define SMMU_ST_CY       7

// =============================================================
// max-search control word fields and limits
`define SMMU_MCTL_SIGNED 15
`define SMMU_MCTL_REPORT 14
`define SMMU_S32_MAX     64'sh0000_0000_7fff_ffff
`define SMMU_S32_MIN     64'shffff_ffff_8000_0000

`endif

// ---- smmu_pkg.sv ----
// types shared by the arithmetic unit
package smmu_pkg;

	// =============================================================
	// operation codes and sequencer states
	typedef enum logic [2:0] {op_sub, op_mul16, op_mul32, op_div16, op_div32, op_max} smmu_op_t;
	typedef enum logic [1:0] {st_idle, st_calc, st_scan} smmu_state_t;
	typedef logic [15:0] smmu_word_t;

endpackage : smmu_pkg

// ---- smmu_seq_model.sv ----
// sequencer model: axi4-lite master with register access tasks
`timescale 1ns/10ps
`include "smmu_defines.svh"

module smmu_seq_model
(
	// clock
	input  wire logic                   aclk,
	// write channels
	output logic [`SMMU_ADDR_W-1:0]     awaddr,
	output logic                        awvalid,
	input  wire logic                   awready,
	output logic [31:0]                 wdata,
	output logic [3:0]                  wstrb,
	output logic                        wvalid,
	input  wire logic                   wready,
	input  wire logic [1:0]             bresp,
	input  wire logic                   bvalid,
	output logic                        bready,
	// read channels
	output logic [`SMMU_ADDR_W-1:0]     araddr,
	output logic                        arvalid,
	input  wire logic                   arready,
	input  wire logic [31:0]            rdata,
	input  wire logic [1:0]             rresp,
	input  wire logic                   rvalid,
	output logic                        rready
);
	// =============================================================
	// idle levels
	initial
	begin
		{awaddr, awvalid, wdata, wvalid, bready} = '0;
		{araddr, arvalid, rready} = '0;
		wstrb = 4'hf;
	end

	// =============================================================
	// access tasks; callers keep operands put until done
	task automatic wr(input logic [`SMMU_ADDR_W-1:0] a, input logic [31:0] v,
		output logic [1:0] r);
		logic ad;
		logic wd;
		ad = 1'b0;
		wd = 1'b0;
		@(posedge aclk);
		awaddr  <= a;
		awvalid <= 1'b1;
		wdata   <= v;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		forever
		begin
			@(posedge aclk);
			// released lines show the inverse, not a stale value
			if (!ad && awready)
			begin
				ad = 1'b1;
				awvalid <= 1'b0;
				awaddr  <= ~a;
			end
			if (!wd && wready)
			begin
				wd = 1'b1;
				wvalid <= 1'b0;
				wdata  <= ~v;
			end
			if (bvalid)
			begin
				r = bresp;
				bready <= 1'b0;
				break;
			end
		end
	endtask : wr

	task automatic rd(input logic [`SMMU_ADDR_W-1:0] a, output logic [31:0] v,
		output logic [1:0] r);
		@(posedge aclk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		forever
		begin
			@(posedge aclk);
			if (arvalid && arready)
			begin
				arvalid <= 1'b0;
				araddr  <= ~a;
			end
			if (rvalid)
			begin
				v = rdata;
				r = rresp;
				rready <= 1'b0;
				break;
			end
		end
	endtask : rd
endmodule : smmu_seq_model

// ---- smmu_unit_test.sv ----
// self-checking bench for the arithmetic unit
`timescale 1ns/10ps
`include "smmu_defines.svh"

module smmu_unit_test;
	// =============================================================
	// signals
	logic                    aclk, aresetn;
	logic [`SMMU_ADDR_W-1:0] awaddr, araddr;
	logic [31:0]             wdata, rdata, d;
	logic [3:0]              wstrb;
	logic [1:0]              bresp, rresp, r;
	logic                    awvalid, awready, wvalid, wready, bvalid, bready;
	logic                    arvalid, arready, rvalid, rready;
	logic [15:0]             mv[4] = '{16'h0005, 16'h8000, 16'h0007, 16'h0007};
	int                      miscompares, cmp_count, i;

	always #10 aclk = ~aclk;

	smmu_unit i_smmu_unit (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
		.rresp, .rvalid, .rready);
	smmu_seq_model i_smmu_seq_model (.aclk, .awaddr, .awvalid, .awready, .wdata, .wstrb,
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
		.rresp, .rvalid, .rready);

	// =============================================================
	// helpers
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e)
		begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	task automatic wr(input logic [`SMMU_ADDR_W-1:0] a, input logic [31:0] v);
		i_smmu_seq_model.wr(a, v, r);
		chk("bresp", {30'h0, r}, {30'h0, `SMMU_RESP_OKAY});
	endtask : wr

	// start an operation, poll done, then compare flags under mask and results
	task automatic run(input logic [31:0] a, b, c, input logic [15:0] e0, e1, e2, e3,
		input logic [7:0] m, f);
		logic [15:0] e[4];
		int n;
		e = '{e0, e1, e2, e3};
		n = 0;
		wr(`SMMU_OPA_OFF, a);
		wr(`SMMU_OPB_OFF, b);
		wr(`SMMU_CTRL_OFF, c);
		do
		begin
			i_smmu_seq_model.rd(`SMMU_STATUS_OFF, d, r);
			n++;
		end
		while (d[`SMMU_ST_DONE] !== 1'b1 && n < 2000);
		chk("done", {31'h0, d[`SMMU_ST_DONE]}, 32'h1);
		chk("flags", {24'h0, d[7:0] & m}, {24'h0, f});
		for (int k = 0; k < 4; k++)
		begin
			i_smmu_seq_model.rd(12'(`SMMU_RES0_OFF + 4 * k), d, r);
			chk("result", d, {16'h0, e[k]});
		end
	endtask : run

	task automatic final_report;
		if (miscompares == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : final_report

	// =============================================================
	// watchdog, far beyond the several hundred cycles the tests need
	initial
	begin
		repeat (40000) @(posedge aclk);
		miscompares++;
		final_report;
	end

	// =============================================================
	// tests
	initial
	begin
		aclk = 1'b0;
		aresetn = 1'b0;
		miscompares = 0;
		cmp_count = 0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		i_smmu_seq_model.rd(`SMMU_STATUS_OFF, d, r);
		chk("status reset", d, 32'h0);
		i_smmu_seq_model.rd(12'h01c, d, r);
		chk("unmapped rresp", {30'h0, r}, {30'h0, `SMMU_RESP_SLVERR});
		chk("unmapped rdata", d, 32'h0);
		i_smmu_seq_model.wr(12'h030, 32'h1, r);
		chk("unmapped bresp", {30'h0, r}, {30'h0, `SMMU_RESP_SLVERR});
		i_smmu_seq_model.wr(`SMMU_STATUS_OFF, 32'hff, r);
		chk("status write bresp", {30'h0, r}, {30'h0, `SMMU_RESP_SLVERR});
		run(32'h6b3c167d, 32'hef258c47, 32'h100, 16'h8a36, 16'h7c16, 16'h0, 16'h0, 8'hfc, 8'h80);
		run(32'h7fffffff, 32'hffffffff, 32'h100, 16'h0, 16'h8000, 16'h0, 16'h0, 8'h60, 8'h20);
		run(32'h80000000, 32'h1, 32'h100, 16'hffff, 16'h7fff, 16'h0, 16'h0, 8'h60, 8'h40);
		run(32'h80000000, 32'h0, 32'h500, 16'hffff, 16'h7fff, 16'h0, 16'h0, 8'h60, 8'h40);
		run(32'hfffe, 32'h3, 32'h101, 16'hfffa, 16'hffff, 16'h0, 16'h0, 8'h1c, 8'h10);
		run(32'h0, 32'h1234, 32'h101, 16'h0, 16'h0, 16'h0, 16'h0, 8'h1c, 8'h08);
		run(32'h80000000, 32'h2, 32'h102, 16'h0, 16'h0, 16'hffff, 16'hffff, 8'h1c, 8'h10);
		run(32'hfff9, 32'h2, 32'h103, 16'hfffd, 16'hffff, 16'hffff, 16'hffff, 8'h1c, 8'h10);
		run(32'h5, 32'h0, 32'h103, 16'hfffd, 16'hffff, 16'hffff, 16'hffff, 8'h1c, 8'h14);
		run(32'hfffe7960, 32'h7, 32'h104, 16'hc833, 16'hffff, 16'hfffb, 16'hffff, 8'h1c, 8'h10);
		run(32'h5, 32'h0, 32'h104, 16'hc833, 16'hffff, 16'hfffb, 16'hffff, 8'h1c, 8'h14);
		run(32'h3, 32'h7, 32'h104, 16'h0, 16'h0, 16'h3, 16'h0, 8'h1c, 8'h08);
		run(32'h5, 32'h0, 32'h106, 16'h0, 16'h0, 16'h3, 16'h0, 8'h1c, 8'h0c);
		wr(`SMMU_PTR_OFF, 32'h000a);
		run(32'h1, 32'h1, 32'h901, 16'h0, 16'h0, 16'h3, 16'h0, 8'h1c, 8'h0c);
		for (i = 0; i < 4; i++)
			wr(12'(`SMMU_MEM_BASE + 4 * (16 + i)), {16'h0, mv[i]});
		wr(`SMMU_MEM_BASE + 12'h024, 32'h0);
		wr(`SMMU_MEM_BASE + 12'h028, 32'h0);
		wr(`SMMU_RANGE_OFF, 32'd16);
		wr(`SMMU_MCTL_OFF, 32'h4004);
		run(32'h0, 32'h0, 32'h305, 16'h8000, 16'h0001, 16'h3, 16'h0, 8'h1c, 8'h10);
		wr(`SMMU_MCTL_OFF, 32'hc004);
		run(32'h0, 32'h0, 32'h305, 16'h0007, 16'h0002, 16'h3, 16'h0, 8'h1c, 8'h00);
		wr(`SMMU_RANGE_OFF, 32'd9);
		wr(`SMMU_MCTL_OFF, 32'h4002);
		run(32'h0, 32'h0, 32'h305, 16'h0, 16'h0009, 16'h3, 16'h0, 8'h1c, 8'h08);
		wr(`SMMU_MCTL_OFF, 32'h400a);
		run(32'h0, 32'h0, 32'h305, 16'h0, 16'h0009, 16'h3, 16'h0, 8'h1c, 8'h0c);
		wr(`SMMU_RANGE_OFF, 32'd14);
		wr(`SMMU_MCTL_OFF, 32'h4004);
		run(32'h0, 32'h0, 32'h305, 16'h0, 16'h0009, 16'h3, 16'h0, 8'h1c, 8'h0c);
		wr(`SMMU_RANGE_OFF, 32'd16);
		run(32'h0, 32'h0, 32'h105, 16'h0, 16'h0009, 16'h3, 16'h0, 8'h1c, 8'h0c);
		final_report;
	end
endmodule : smmu_unit_test
